//--- logic/mdio_event_regs.svh
`ifndef MDIO_EVENT_REGS_SVH
`define MDIO_EVENT_REGS_SVH

// ============================================================
// Register offsets (byte addresses)
`define OFF_LINK_STATE        8'h00
`define OFF_LINK_CHG_MASKED   8'h04
`define OFF_CMD_DONE_RAW      8'h08
`define OFF_CMD_DONE_MASKED   8'h0c
`define OFF_CMD_MASK_SET      8'h10
`define OFF_CMD_MASK_CLEAR    8'h14
`define OFF_PHY_MON_SEL0      8'h18
`define OFF_PHY_MON_SEL1      8'h1c

// ============================================================
// Field positions
`define SEL_ADDR_MSB          4
`define SEL_ADDR_LSB          0
`define SEL_ENABLE_BIT        6
`define EVT_BITS_MSB          1

// ============================================================
// Reset values
`define RST_LINK_STATE        32'h0000_0000
`define RST_EVT_BITS          2'h0
`define RST_PHY_ADDR          5'h00

// ============================================================
// Timing counts
`define SYNC_STAGES           2

`endif

//--- logic/mdio_event_pkg.sv
package mdio_event_pkg;

    // ============================================================
    // Bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } regbus_req_t;

    // ============================================================
    // Result of one PHY status read
    typedef struct packed {
        logic [4:0] phyAddr;
        logic       linkUp;
        logic       ack;
    } status_evt_t;

    // ============================================================
    // Monitor select register
    typedef struct packed {
        logic       enable;
        logic [4:0] phyAddr;
    } phy_sel_t;

endpackage : mdio_event_pkg

//--- logic/link_event_sync.sv
`timescale 1ns/1ps

module link_event_sync #(
    parameter int W = 8
) (
    input  wire logic         srcClk,
    input  wire logic         srcRst,
    input  wire logic         srcValid,
    input  wire logic [W-1:0] srcData,
    output logic              srcBusy,
    input  wire logic         dstClk,
    input  wire logic         dstRst,
    output logic              dstValid,
    output logic [W-1:0]      dstData
);

    logic         reqTgl;
    logic [W-1:0] dataHold;
    logic         ackMeta;
    logic         ackSync;
    logic         reqMeta;
    logic         reqSync;
    logic         ackTgl;

    // ============================================================
    // Source side: data held still until the ack returns
    always_ff @(posedge srcClk) begin
        if (srcRst) begin
            reqTgl <= 1'b0;
        end else if (srcValid && !srcBusy) begin
            reqTgl <= ~reqTgl;
        end
    end

    always_ff @(posedge srcClk) begin
        if (srcValid && !srcBusy) begin
            dataHold <= srcData;
        end
    end

    always_ff @(posedge srcClk) begin
        if (srcRst) begin
            ackMeta <= 1'b0;
            ackSync <= 1'b0;
        end else begin
            ackMeta <= ackTgl;
            ackSync <= ackMeta;
        end
    end

    assign srcBusy = (reqTgl != ackSync);

    // ============================================================
    // Destination side
    always_ff @(posedge dstClk) begin
        if (dstRst) begin
            reqMeta <= 1'b0;
            reqSync <= 1'b0;
        end else begin
            reqMeta <= reqTgl;
            reqSync <= reqMeta;
        end
    end

    always_ff @(posedge dstClk) begin
        if (dstRst) begin
            ackTgl   <= 1'b0;
            dstValid <= 1'b0;
        end else begin
            ackTgl   <= reqSync;
            dstValid <= (reqSync != ackTgl);
        end
    end

    // Hold is stable here: source waits for the ack
    always_ff @(posedge dstClk) begin
        if (dstRst) begin
            dstData <= '0;
        end else if (reqSync != ackTgl) begin
            dstData <= dataHold;
        end
    end

endmodule : link_event_sync

//--- logic/mdio_event_status_regs.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "mdio_event_regs.svh"

module mdio_event_status_regs (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire mdio_event_pkg::regbus_req_t busReq,
    output logic [31:0]                     rdData,
    input  wire logic                       linkClk,
    input  wire logic                       statusValid,
    input  wire mdio_event_pkg::status_evt_t statusResult,
    input  wire logic [1:0]                 cmdDone
);
    import mdio_event_pkg::*;

    // ============================================================
    // Functions
    function automatic logic isWrite(input regbus_req_t r, input logic [7:0] off);
        return r.wr && (r.addr == off);
    endfunction : isWrite

    // Set wins over a clear in the same cycle
    function automatic logic [1:0] nextSticky(input logic [1:0] cur,
                                              input logic [1:0] set,
                                              input logic [1:0] clr);
        return set | (cur & ~clr);
    endfunction : nextSticky

    // ============================================================
    // Link domain reset
    logic linkRstMeta;
    logic linkRst;

    always_ff @(posedge linkClk) begin
        linkRstMeta <= rst;
        linkRst     <= linkRstMeta;
    end

    // ============================================================
    // Link domain: one pending slot per event kind
    logic        statusPend;
    status_evt_t statusHold;
    logic        statusBusy;
    logic        statusSend;
    logic [1:0]  cmdPend;
    logic        cmdBusy;
    logic        cmdSend;

    assign statusSend = statusPend && !statusBusy;
    assign cmdSend    = (cmdPend != 2'h0) && !cmdBusy;

    // Newer status overwrites a waiting one: latest link wins
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            statusPend <= 1'b0;
        end else if (statusValid) begin
            statusPend <= 1'b1;
        end else if (statusSend) begin
            statusPend <= 1'b0;
        end
    end

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            statusHold <= '0;
        end else if (statusValid) begin
            statusHold <= statusResult;
        end
    end

    // Completions merge while waiting, none is lost
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            cmdPend <= `RST_EVT_BITS;
        end else begin
            cmdPend <= (cmdSend ? 2'h0 : cmdPend) | cmdDone;
        end
    end

    // ============================================================
    // Crossings
    logic        statusEv;
    status_evt_t statusEvData;
    logic        cmdEv;
    logic [1:0]  cmdEvData;

    link_event_sync #(
        .W ($bits(status_evt_t))
    ) u_status_sync (
        .srcClk   (linkClk),
        .srcRst   (linkRst),
        .srcValid (statusSend),
        .srcData  (statusHold),
        .srcBusy  (statusBusy),
        .dstClk   (mclk),
        .dstRst   (rst),
        .dstValid (statusEv),
        .dstData  (statusEvData)
    );

    link_event_sync #(
        .W (2)
    ) u_cmd_sync (
        .srcClk   (linkClk),
        .srcRst   (linkRst),
        .srcValid (cmdSend),
        .srcData  (cmdPend),
        .srcBusy  (cmdBusy),
        .dstClk   (mclk),
        .dstRst   (rst),
        .dstValid (cmdEv),
        .dstData  (cmdEvData)
    );

    // ============================================================
    // Register write decode
    logic       wrLinkMasked;
    logic       wrCmdRaw;
    logic       wrCmdMasked;
    logic       wrMaskSet;
    logic       wrMaskClear;
    logic [1:0] wrBits;

    assign wrLinkMasked = isWrite(busReq, `OFF_LINK_CHG_MASKED);
    assign wrCmdRaw     = isWrite(busReq, `OFF_CMD_DONE_RAW);
    assign wrCmdMasked  = isWrite(busReq, `OFF_CMD_DONE_MASKED);
    assign wrMaskSet    = isWrite(busReq, `OFF_CMD_MASK_SET);
    assign wrMaskClear  = isWrite(busReq, `OFF_CMD_MASK_CLEAR);
    assign wrBits       = busReq.wdata[`EVT_BITS_MSB:0];

    // ============================================================
    // Monitor select registers
    phy_sel_t phySel [2];

    always_ff @(posedge mclk) begin
        if (rst) begin
            phySel[0] <= '{enable: 1'b0, phyAddr: `RST_PHY_ADDR};
            phySel[1] <= '{enable: 1'b0, phyAddr: `RST_PHY_ADDR};
        end else begin
            if (isWrite(busReq, `OFF_PHY_MON_SEL0)) begin
                phySel[0].enable  <= busReq.wdata[`SEL_ENABLE_BIT];
                phySel[0].phyAddr <= busReq.wdata[`SEL_ADDR_MSB:`SEL_ADDR_LSB];
            end
            if (isWrite(busReq, `OFF_PHY_MON_SEL1)) begin
                phySel[1].enable  <= busReq.wdata[`SEL_ENABLE_BIT];
                phySel[1].phyAddr <= busReq.wdata[`SEL_ADDR_MSB:`SEL_ADDR_LSB];
            end
        end
    end

    // ============================================================
    // Link state and change detection
    logic [31:0] linkState;
    logic        nowUp;
    logic        linkFlip;
    logic [1:0]  selHit;

    assign nowUp    = statusEvData.linkUp && statusEvData.ack;
    assign linkFlip = statusEv && (linkState[statusEvData.phyAddr] != nowUp);

    always_comb begin
        for (int n = 0; n < 2; n++) begin
            selHit[n] = linkFlip && phySel[n].enable
                        && (statusEvData.phyAddr == phySel[n].phyAddr);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            linkState <= `RST_LINK_STATE;
        end else if (statusEv) begin
            linkState[statusEvData.phyAddr] <= nowUp;
        end
    end

    // ============================================================
    // Masked link-change bits
    logic [1:0] linkChgMasked;

    always_ff @(posedge mclk) begin
        if (rst) begin
            linkChgMasked <= `RST_EVT_BITS;
        end else begin
            linkChgMasked <= nextSticky(linkChgMasked, selHit,
                                        wrLinkMasked ? wrBits : 2'h0);
        end
    end

    // ============================================================
    // Command-done bits and mask
    logic [1:0] cmdDoneNow;
    logic [1:0] cmdDoneRaw;
    logic [1:0] cmdDoneMasked;
    logic [1:0] cmdMask;

    assign cmdDoneNow = cmdEv ? cmdEvData : 2'h0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            cmdDoneRaw <= `RST_EVT_BITS;
        end else begin
            cmdDoneRaw <= nextSticky(cmdDoneRaw, cmdDoneNow,
                                     wrCmdRaw ? wrBits : 2'h0);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cmdDoneMasked <= `RST_EVT_BITS;
        end else begin
            cmdDoneMasked <= nextSticky(cmdDoneMasked, cmdDoneNow & cmdMask,
                                        wrCmdMasked ? wrBits : 2'h0);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cmdMask <= `RST_EVT_BITS;
        end else if (wrMaskSet) begin
            cmdMask <= cmdMask | wrBits;
        end else if (wrMaskClear) begin
            cmdMask <= cmdMask & ~wrBits;
        end
    end

    // ============================================================
    // Read port: data in the cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (rst || !busReq.rd) begin
            rdData <= 32'h0000_0000;
        end else begin
            case (busReq.addr)
                `OFF_LINK_STATE:      rdData <= linkState;
                `OFF_LINK_CHG_MASKED: rdData <= {30'h0, linkChgMasked};
                `OFF_CMD_DONE_RAW:    rdData <= {30'h0, cmdDoneRaw};
                `OFF_CMD_DONE_MASKED: rdData <= {30'h0, cmdDoneMasked};
                `OFF_CMD_MASK_SET:    rdData <= {30'h0, cmdMask};
                `OFF_CMD_MASK_CLEAR:  rdData <= {30'h0, cmdMask};
                `OFF_PHY_MON_SEL0:    rdData <= {25'h0, phySel[0].enable, 1'b0,
                                                 phySel[0].phyAddr};
                `OFF_PHY_MON_SEL1:    rdData <= {25'h0, phySel[1].enable, 1'b0,
                                                 phySel[1].phyAddr};
                default:              rdData <= 32'h0000_0000;
            endcase
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    AST_LINK_GATE0: assert property (
        $rose(linkChgMasked[0]) |-> $past(statusEv && phySel[0].enable
            && statusEvData.phyAddr == phySel[0].phyAddr
            && linkState[statusEvData.phyAddr] != nowUp))
        else $error("link masked bit 0 set without enabled change");

    AST_LINK_MAP1: assert property (
        (statusEv && phySel[1].enable && statusEvData.phyAddr == phySel[1].phyAddr
            && linkState[statusEvData.phyAddr] != nowUp) |=> linkChgMasked[1])
        else $error("change on select 1 address did not set bit 1");

    AST_LINK_W1C: assert property (
        (wrLinkMasked && wrBits[0] && !selHit[0]) |=> !linkChgMasked[0])
        else $error("link masked bit 0 not cleared by write of 1");

    AST_LINK_W0: assert property (
        (wrLinkMasked && !wrBits[1] && linkChgMasked[1]) |=> linkChgMasked[1])
        else $error("link masked bit 1 lost on write of 0");

    AST_RAW_SET: assert property (
        (cmdEv && cmdEvData[0]) |=> cmdDoneRaw[0])
        else $error("raw done bit 0 not set on completion");

    AST_RAW_W1C: assert property (
        (wrCmdRaw && wrBits[1] && !(cmdEv && cmdEvData[1])) |=> !cmdDoneRaw[1])
        else $error("raw done bit 1 not cleared by write of 1");

    AST_MASKED_GATE: assert property (
        $rose(cmdDoneMasked[0]) |-> $past(cmdEv && cmdEvData[0] && cmdMask[0]))
        else $error("masked done bit 0 set without mask");

    AST_MASKED_W1C: assert property (
        (wrCmdMasked && wrBits[0] && !cmdEv) ##1 (!cmdEv)[*2] |-> !cmdDoneMasked[0])
        else $error("masked done bit 0 not cleared by write of 1");

    AST_LINK_STATE: assert property (
        statusEv |=> linkState[$past(statusEvData.phyAddr)]
            == $past(statusEvData.linkUp && statusEvData.ack))
        else $error("link state bit does not follow link and ack");

    AST_MASK_SET: assert property (
        wrMaskSet |=> cmdMask == ($past(cmdMask) | $past(wrBits)))
        else $error("mask set write did not add exactly its ones");

    AST_MASK_CLEAR: assert property (
        wrMaskClear |=> cmdMask == ($past(cmdMask) & ~$past(wrBits)))
        else $error("mask clear write did not drop exactly its ones");

    AST_RSVD_ZERO: assert property (
        (busReq.rd && busReq.addr == `OFF_CMD_DONE_RAW) |=> rdData[31:2] == 30'h0)
        else $error("reserved bits of raw done read nonzero");

    AST_LINK_MAP0: assert property (
        (statusEv && phySel[0].enable && statusEvData.phyAddr == phySel[0].phyAddr
            && linkState[statusEvData.phyAddr] != nowUp) |=> linkChgMasked[0])
        else $error("change on select 0 address did not set bit 0");

    AST_LINK_QUIET: assert property (
        (!statusEv && !linkChgMasked[1]) |=> !linkChgMasked[1])
        else $error("link masked bit 1 set with no status result");

    AST_RAW_W0: assert property (
        (wrCmdRaw && !wrBits[0] && cmdDoneRaw[0]) |=> cmdDoneRaw[0])
        else $error("raw done bit 0 lost on write of 0");

    AST_MASKED_GATE1: assert property (
        (cmdEv && cmdEvData[1] && !cmdMask[1] && !cmdDoneMasked[1]) |=> !cmdDoneMasked[1])
        else $error("masked done bit 1 set while its mask bit is 0");

    AST_MASKED_W0: assert property (
        (wrCmdMasked && !wrBits[1] && cmdDoneMasked[1]) |=> cmdDoneMasked[1])
        else $error("masked done bit 1 lost on write of 0");

    AST_LINK_HOLD: assert property (
        !statusEv |=> $stable(linkState))
        else $error("link state changed without a status result");

    AST_RDATA_IDLE: assert property (
        !busReq.rd |=> rdData == 32'h0000_0000)
        else $error("read data nonzero outside the cycle after a read");

    CVR_LINK_EVT: cover property ($rose(linkChgMasked[0]));
    CVR_LINK_EVT1: cover property ($rose(linkChgMasked[1]));
    CVR_CMD_MASKED: cover property ($rose(cmdDoneMasked[1]));
    CVR_RAW_DONE: cover property ($rose(cmdDoneRaw[0]));
    CVR_SET_AND_CLEAR: cover property (wrCmdRaw && cmdEv);

endmodule : mdio_event_status_regs

//--- tb/mdio_phy_model.sv
`timescale 1ns/1ps

// ============================================================
// Far-side engine: PHY status reads and access command completions
module mdio_phy_model (
    input  wire logic                    linkClk,
    output logic                         statusValid,
    output mdio_event_pkg::status_evt_t  statusResult,
    output logic [1:0]                   cmdDone
);
    import mdio_event_pkg::*;

    logic busy;

    initial begin
        statusValid  = 1'b0;
        statusResult = '0;
        cmdDone      = 2'h0;
        busy         = 1'b0;
    end

    // Released result lines churn, so a stale value never passes for data
    always @(posedge linkClk) begin
        if (!busy) begin
            statusResult <= status_evt_t'($urandom);
        end
    end

    // Gap of at least 12 link cycles, so each result crosses on its own
    task automatic report(input logic [4:0] a, input logic up, input logic ack, input int gap);
        busy = 1'b1;
        @(posedge linkClk);
        statusValid  <= 1'b1;
        statusResult <= '{phyAddr: a, linkUp: up, ack: ack};
        @(posedge linkClk);
        statusValid <= 1'b0;
        busy = 1'b0;
        repeat (gap) @(posedge linkClk);
    endtask : report

    task automatic finish(input logic [1:0] bits, input int gap);
        @(posedge linkClk);
        cmdDone <= bits;
        @(posedge linkClk);
        cmdDone <= 2'h0;
        repeat (gap) @(posedge linkClk);
    endtask : finish
endmodule : mdio_phy_model

//--- tb/mdio_event_status_regs_bench.sv
`timescale 1ns/1ps
`include "mdio_event_regs.svh"

module mdio_event_status_regs_bench;
    import mdio_event_pkg::*;

    logic        mclk;
    logic        rst;
    logic        linkClk;
    logic        statusValid;
    logic [1:0]  cmdDone;
    logic [31:0] rdData;
    regbus_req_t busReq;
    status_evt_t statusResult;
    int          errors;
    int          checked;
    logic [31:0] lnk;
    logic [31:0] w;
    logic [1:0]  lkm;
    logic [1:0]  raw;
    logic [1:0]  cmm;
    logic [1:0]  mask;
    logic [1:0]  bits;
    phy_sel_t    sel [2];

    mdio_event_status_regs mdio_event_status_regs_i (
        .mclk         (mclk),
        .rst          (rst),
        .busReq       (busReq),
        .rdData       (rdData),
        .linkClk      (linkClk),
        .statusValid  (statusValid),
        .statusResult (statusResult),
        .cmdDone      (cmdDone)
    );

    mdio_phy_model mdio_phy_model_i (
        .linkClk      (linkClk),
        .statusValid  (statusValid),
        .statusResult (statusResult),
        .cmdDone      (cmdDone)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Link clock offset so the two domains never share an edge
    initial begin
        linkClk = 1'b0;
        #1.3;
        forever #3 linkClk = ~linkClk;
    end

    // ============================================================
    // Comparison, bus cycles, reference model
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        busReq.wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge mclk);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk);
        busReq.rd <= 1'b0;
        #1;
        check(rdData, exp, msg);
    endtask : rd_chk

    task automatic check_all;
        logic [31:0] s0;
        logic [31:0] s1;
        s0 = {25'h0, sel[0].enable, 1'b0, sel[0].phyAddr};
        s1 = {25'h0, sel[1].enable, 1'b0, sel[1].phyAddr};
        rd_chk(`OFF_PHY_MON_SEL0, s0, "select 0");
        rd_chk(`OFF_PHY_MON_SEL1, s1, "select 1");
        rd_chk(`OFF_CMD_MASK_CLEAR, {30'h0, mask}, "mask clear view");
        rd_chk(`OFF_LINK_STATE, lnk, "link state");
        rd_chk(`OFF_LINK_CHG_MASKED, {30'h0, lkm}, "link masked");
        rd_chk(`OFF_CMD_DONE_RAW, {30'h0, raw}, "cmd raw");
        rd_chk(`OFF_CMD_DONE_MASKED, {30'h0, cmm}, "cmd masked");
        rd_chk(`OFF_CMD_MASK_SET, {30'h0, mask}, "mask");
    endtask : check_all

    task automatic set_sel(input int n, input logic en, input logic [4:0] a);
        wr((n == 0) ? `OFF_PHY_MON_SEL0 : `OFF_PHY_MON_SEL1, {25'h0, en, 1'b0, a});
        sel[n] = '{enable: en, phyAddr: a};
    endtask : set_sel

    task automatic ev_status(input logic [4:0] a, input logic up, input logic ack);
        logic nv;
        mdio_phy_model_i.report(a, up, ack, 12 + ($urandom % 8));
        nv = up & ack;
        if (nv != lnk[a]) begin
            for (int n = 0; n < 2; n++) begin
                if (sel[n].enable && sel[n].phyAddr == a) lkm[n] = 1'b1;
            end
        end
        lnk[a] = nv;
        repeat (10) @(posedge mclk);
    endtask : ev_status

    task final_report;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // Hang guard well beyond the few thousand cycles the tests need
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        final_report;
    end

    // ============================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        busReq = '0;
        errors = 0;
        checked = 0;
        lnk = 32'h0;
        lkm = 2'h0;
        raw = 2'h0;
        cmm = 2'h0;
        mask = 2'h0;
        sel[0] = '0;
        sel[1] = '0;
        void'($urandom(32'he6865f47));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        check_all;
        rd_chk(8'h20, 32'h0, "unmapped");
        @(posedge mclk);
        #1;
        check(rdData, 32'h0, "read data idle");
        // Link state is read only: this write must leave it alone
        wr(`OFF_LINK_STATE, 32'hffff_ffff);
        set_sel(0, 1'b1, 5'h03);
        set_sel(1, 1'b0, 5'h07);
        for (int i = 0; i < 24; i++) begin
            if (i == 12) set_sel(1, 1'b1, 5'h07);
            if (i == 18) set_sel(0, 1'b0, 5'h03);
            w = $urandom;
            ev_status((w[1:0] == 2'h0) ? 5'h03 : (w[1:0] == 2'h1) ? 5'h07 : w[8:4], w[9], w[10]);
            check_all;
            w = $urandom;
            wr(`OFF_LINK_CHG_MASKED, w);
            lkm = lkm & ~w[1:0];
        end
        check_all;
        wr(`OFF_CMD_MASK_SET, 32'hffff_fffc);
        wr(`OFF_CMD_MASK_SET, 32'h0000_0001);
        mask = 2'h1;
        for (int i = 0; i < 20; i++) begin
            if (i == 8) begin
                wr(`OFF_CMD_MASK_SET, 32'h0000_0002);
                mask = 2'h3;
            end
            if (i == 14) begin
                wr(`OFF_CMD_MASK_CLEAR, 32'h0000_0001);
                mask = 2'h2;
            end
            bits = 2'($urandom);
            mdio_phy_model_i.finish(bits, 2 + ($urandom % 12));
            raw = raw | bits;
            cmm = cmm | (bits & mask);
            repeat (10) @(posedge mclk);
            check_all;
            w = $urandom;
            wr(`OFF_CMD_DONE_RAW, w);
            raw = raw & ~w[1:0];
            w = $urandom;
            wr(`OFF_CMD_DONE_MASKED, w);
            cmm = cmm & ~w[1:0];
        end
        check_all;
        final_report;
    end
endmodule : mdio_event_status_regs_bench
